// >>> include/bst_pkg.sv
package bst_pkg;
   // ****************************************
   // Register sizes and instruction codes
   // ****************************************
   localparam int BST_IR_W = 3;
   localparam int BST_ID_W = 32;
   localparam int BST_BSR_W = 89;
   localparam logic [2:0] BST_I_EXTEST = 3'h0;
   localparam logic [2:0] BST_I_IDCODE = 3'h1;
   localparam logic [2:0] BST_I_SAMPZ = 3'h2;
   localparam logic [2:0] BST_I_SAMPLE = 3'h4;
   localparam logic [2:0] BST_I_BYPASS = 3'h7;
   // Reset values
   localparam logic [2:0] BST_IR_RST = 3'h1;
   localparam logic [2:0] BST_IR_CAPT = 3'h1;
   localparam logic BST_OE_RST = 1'h1;
   // Index of the internal output-enable cell (cell 89)
   localparam int BST_OE_IDX = 88;

   // ****************************************
   // Controller states
   // ****************************************
   typedef enum logic [3:0] {
      BST_TLR = 4'h0, BST_RTI = 4'h1, BST_SDS = 4'h2, BST_CDR = 4'h3,
      BST_SHDR = 4'h4, BST_E1DR = 4'h5, BST_PDR = 4'h6, BST_E2DR = 4'h7,
      BST_UDR = 4'h8, BST_SIS = 4'h9, BST_CIR = 4'hA, BST_SHIR = 4'hB,
      BST_E1IR = 4'hC, BST_PIR = 4'hD, BST_E2IR = 4'hE, BST_UIR = 4'hF
   } bst_state_t;

   // Decoded instruction effects
   typedef struct packed {
      logic sel_bsr;
      logic sel_id;
      logic sel_byp;
      logic force_hiz;
      logic extest;
   } bst_dec_t;
endpackage

// >>> rtl/bst_tap.sv
// Behaviour
// - Serial paths: 3-bit instruction, 1-bit bypass, 32-bit ID, 89-cell chain.
// - Code 000 captures pins, selects boundary chain, outputs high impedance.
// - Code 001 loads ID register and selects it; memory unaffected.
// - Code 010 captures pins, selects boundary chain, drivers high impedance.
// - Code 100 captures pins, selects boundary chain; memory unaffected.
// - Code 111 selects the one-bit bypass; memory unaffected.
// - Cell 89 is internal, tied to no ball, preset to one.
// - Cells of unconnected balls are preset to zero.
// - Under code 000 latched cell 89 enables or floats the output bus.
// - Output-enable cell is one at power-up and in test-logic-reset.
// - Mode select sampled and state stepped on each rising test clock.
// - Bit 0 of the ID register is loaded as one on every capture.
`timescale 1ns/1ps
`default_nettype none
module bst_tap
   import bst_pkg::*;
#(
   parameter logic [BST_ID_W-1:0] ID_VALUE = 32'h0ABC_0001, // arbitrary
   parameter logic [BST_BSR_W-1:0] NC_MASK = '0
) (
   input wire logic mclk_i,
   input wire logic nrst_i,
   input wire logic tck_i,
   input wire logic tms_i,
   input wire logic tdi_i,
   output logic tdo_o,
   output logic tdo_oe_o,
   input wire logic [BST_BSR_W-2:0] pins_i,
   output logic [BST_BSR_W-2:0] pins_o,
   output logic test_drive_o,
   output logic out_hiz_o,
   output logic outbus_en_o
);
   // ****************************************
   // Helpers
   // ****************************************
   function automatic bst_dec_t decode(input logic [2:0] ir);
      bst_dec_t d;
      d = '0;
      case (ir)
         BST_I_EXTEST: begin
            d.sel_bsr = 1'b1;
            d.extest = 1'b1;
         end
         BST_I_IDCODE: d.sel_id = 1'b1;
         BST_I_SAMPZ: begin
            d.sel_bsr = 1'b1;
            d.force_hiz = 1'b1;
         end
         BST_I_SAMPLE: d.sel_bsr = 1'b1;
         default: d.sel_byp = 1'b1;
      endcase
      return d;
   endfunction

   // Preset value of the boundary chain
   function automatic logic [BST_BSR_W-1:0] bsr_preset();
      logic [BST_BSR_W-1:0] v;
      v = '0;
      v[BST_OE_IDX] = BST_OE_RST;
      return v;
   endfunction

   // ****************************************
   // Controller state machine (test clock)
   // ****************************************
   bst_state_t state_ff, nxt_state;

   // Standard 16-state walk on sampled mode select
   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         BST_TLR: nxt_state = tms_i ? BST_TLR : BST_RTI;
         BST_RTI: nxt_state = tms_i ? BST_SDS : BST_RTI;
         BST_SDS: nxt_state = tms_i ? BST_SIS : BST_CDR;
         BST_CDR: nxt_state = tms_i ? BST_E1DR : BST_SHDR;
         BST_SHDR: nxt_state = tms_i ? BST_E1DR : BST_SHDR;
         BST_E1DR: nxt_state = tms_i ? BST_UDR : BST_PDR;
         BST_PDR: nxt_state = tms_i ? BST_E2DR : BST_PDR;
         BST_E2DR: nxt_state = tms_i ? BST_UDR : BST_SHDR;
         BST_UDR: nxt_state = tms_i ? BST_SDS : BST_RTI;
         BST_SIS: nxt_state = tms_i ? BST_TLR : BST_CIR;
         BST_CIR: nxt_state = tms_i ? BST_E1IR : BST_SHIR;
         BST_SHIR: nxt_state = tms_i ? BST_E1IR : BST_SHIR;
         BST_E1IR: nxt_state = tms_i ? BST_UIR : BST_PIR;
         BST_PIR: nxt_state = tms_i ? BST_E2IR : BST_PIR;
         BST_E2IR: nxt_state = tms_i ? BST_UIR : BST_SHIR;
         BST_UIR: nxt_state = tms_i ? BST_SDS : BST_RTI;
         default: nxt_state = BST_TLR;
      endcase
   end

   always_ff @(posedge tck_i or negedge nrst_i) begin
      if (!nrst_i) begin
         state_ff <= BST_TLR;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // ****************************************
   // Pin synchroniser (test clock)
   // ****************************************
   logic [BST_BSR_W-2:0] pin_s1_ff, pin_s2_ff, pin_s3_ff, pin_q_ff;
   logic [BST_BSR_W-2:0] nxt_pin_s1, nxt_pin_s2, nxt_pin_s3, nxt_pin_q;
   logic [BST_BSR_W-2:0] pin_diff, cap_pins;

   // Ball states pass three stages; a bit moves once stages agree
   always_comb begin
      nxt_pin_s1 = pins_i;
      nxt_pin_s2 = pin_s1_ff;
      nxt_pin_s3 = pin_s2_ff;
      pin_diff = pin_s2_ff ^ pin_s3_ff; // Stages still disagree
      nxt_pin_q = (pin_s3_ff & ~pin_diff) | (pin_q_ff & pin_diff);
   end

   always_ff @(posedge tck_i or negedge nrst_i) begin
      if (!nrst_i) begin
         pin_s1_ff <= '0;
         pin_s2_ff <= '0;
         pin_s3_ff <= '0;
         pin_q_ff <= '0;
      end else begin
         pin_s1_ff <= nxt_pin_s1;
         pin_s2_ff <= nxt_pin_s2;
         pin_s3_ff <= nxt_pin_s3;
         pin_q_ff <= nxt_pin_q;
      end
   end

   // Unconnected balls always read zero
   assign cap_pins = pin_q_ff & ~NC_MASK[BST_BSR_W-2:0];

   // ****************************************
   // Shift registers and instruction
   // ****************************************
   logic [BST_IR_W-1:0] ir_sh_ff, nxt_ir_sh, ir_ff, nxt_ir;
   logic byp_ff, nxt_byp;
   logic [BST_ID_W-1:0] id_ff, nxt_id;
   logic [BST_BSR_W-1:0] bsr_ff, nxt_bsr, upd_ff, nxt_upd;
   logic ext_tk_ff, nxt_ext_tk, hiz_tk_ff, nxt_hiz_tk;
   bst_dec_t dec, nxt_dec;

   assign dec = decode(ir_ff);

   // Capture, shift toward output from bit 0, and update
   always_comb begin
      nxt_ir_sh = ir_sh_ff;
      nxt_ir = ir_ff;
      nxt_byp = byp_ff;
      nxt_id = id_ff;
      nxt_bsr = bsr_ff;
      nxt_upd = upd_ff;
      case (state_ff)
         BST_TLR: begin
            nxt_ir = BST_IR_RST;
            nxt_upd = bsr_preset();
         end
         BST_CIR: nxt_ir_sh = BST_IR_CAPT;
         BST_SHIR: nxt_ir_sh = {tdi_i, ir_sh_ff[BST_IR_W-1:1]};
         BST_UIR: nxt_ir = ir_sh_ff;
         BST_CDR: begin
            nxt_byp = 1'b0;
            nxt_id = {ID_VALUE[BST_ID_W-1:1], 1'b1};
            if (dec.sel_bsr) begin
               // pins captured, unconnected balls read zero
               nxt_bsr = {upd_ff[BST_OE_IDX], cap_pins};
            end
         end
         BST_SHDR: begin
            if (dec.sel_bsr) nxt_bsr = {tdi_i, bsr_ff[BST_BSR_W-1:1]};
            if (dec.sel_id) nxt_id = {tdi_i, id_ff[BST_ID_W-1:1]};
            if (dec.sel_byp) nxt_byp = tdi_i;
         end
         BST_UDR: begin
            if (dec.sel_bsr) nxt_upd = bsr_ff;
         end
         default: begin
         end
      endcase
      // Crossing flags come from the next code, so no decode glitch leaves
      nxt_dec = decode(nxt_ir);
      nxt_ext_tk = nxt_dec.extest;
      nxt_hiz_tk = nxt_dec.extest | nxt_dec.force_hiz;
   end

   always_ff @(posedge tck_i or negedge nrst_i) begin
      if (!nrst_i) begin
         ir_sh_ff <= BST_IR_CAPT;
         ir_ff <= BST_IR_RST;
         byp_ff <= 1'b0;
         id_ff <= '0;
         bsr_ff <= '0;
         upd_ff <= {BST_OE_RST, {(BST_BSR_W-1){1'b0}}};
         ext_tk_ff <= 1'b0;
         hiz_tk_ff <= 1'b0;
      end else begin
         ir_sh_ff <= nxt_ir_sh;
         ir_ff <= nxt_ir;
         byp_ff <= nxt_byp;
         id_ff <= nxt_id;
         bsr_ff <= nxt_bsr;
         upd_ff <= nxt_upd;
         ext_tk_ff <= nxt_ext_tk;
         hiz_tk_ff <= nxt_hiz_tk;
      end
   end

   // ****************************************
   // Test output on falling test clock
   // ****************************************
   logic tdo_ff, nxt_tdo, tdo_oe_ff, nxt_tdo_oe;

   // Select serial output bit
   always_comb begin
      nxt_tdo_oe = (state_ff == BST_SHDR) || (state_ff == BST_SHIR);
      if (state_ff == BST_SHIR) nxt_tdo = ir_sh_ff[0];
      else if (dec.sel_bsr) nxt_tdo = bsr_ff[0];
      else if (dec.sel_id) nxt_tdo = id_ff[0];
      else nxt_tdo = byp_ff;
   end

   always_ff @(negedge tck_i or negedge nrst_i) begin
      if (!nrst_i) begin
         tdo_ff <= 1'b0;
         tdo_oe_ff <= 1'b0;
      end else begin
         tdo_ff <= nxt_tdo;
         tdo_oe_ff <= nxt_tdo_oe;
      end
   end

   assign tdo_o = tdo_ff;
   assign tdo_oe_o = tdo_oe_ff;
   assign pins_o = upd_ff[BST_BSR_W-2:0];

   // ****************************************
   // Output bus control into system clock
   // ****************************************
   logic [2:0] ext_sy_ff, nxt_ext_sy, hiz_sy_ff, nxt_hiz_sy;
   logic [2:0] oe_sy_ff, nxt_oe_sy;
   logic drv_ff, nxt_drv, hiz_ff, nxt_hiz, en_ff, nxt_en;

   // Three-stage synchronisers; change taken when stages two and three agree
   always_comb begin
      nxt_ext_sy = {ext_sy_ff[1:0], ext_tk_ff};
      nxt_hiz_sy = {hiz_sy_ff[1:0], hiz_tk_ff};
      nxt_oe_sy = {oe_sy_ff[1:0], upd_ff[BST_OE_IDX]};
      nxt_drv = (ext_sy_ff[2] == ext_sy_ff[1]) ? ext_sy_ff[2] : drv_ff;
      nxt_hiz = (hiz_sy_ff[2] == hiz_sy_ff[1]) ? hiz_sy_ff[2] : hiz_ff;
      nxt_en = (oe_sy_ff[2] == oe_sy_ff[1]) ? oe_sy_ff[2] : en_ff;
   end

   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         ext_sy_ff <= '0;
         hiz_sy_ff <= '0;
         oe_sy_ff <= '1;
         drv_ff <= 1'b0;
         hiz_ff <= 1'b0;
         en_ff <= BST_OE_RST;
      end else begin
         ext_sy_ff <= nxt_ext_sy;
         hiz_sy_ff <= nxt_hiz_sy;
         oe_sy_ff <= nxt_oe_sy;
         drv_ff <= nxt_drv;
         hiz_ff <= nxt_hiz;
         en_ff <= nxt_en;
      end
   end

   assign test_drive_o = drv_ff;
   assign out_hiz_o = hiz_ff;
   assign outbus_en_o = drv_ff & en_ff;

   // ****************************************
   // Checks
   // ****************************************
   chk_tlr_preset: assert property (
      @(posedge tck_i) disable iff (!nrst_i) state_ff == BST_TLR
      |=> upd_ff[BST_OE_IDX] && ir_ff == BST_I_IDCODE)
      else $error("output-enable cell not preset in reset state");
   chk_id_bit0: assert property (
      @(posedge tck_i) disable iff (!nrst_i)
      state_ff == BST_CDR && dec.sel_id |=> id_ff[0])
      else $error("identification bit 0 not one after capture");
   chk_tms_step: assert property (
      @(posedge tck_i) disable iff (!nrst_i)
      state_ff == BST_RTI && tms_i |=> state_ff == BST_SDS)
      else $error("state not stepped on mode select");
   chk_reset_five: assert property (
      @(posedge tck_i) disable iff (!nrst_i)
      tms_i [*5] |=> state_ff == BST_TLR)
      else $error("five ones did not reach reset state");
   chk_ir_update: assert property (
      @(posedge tck_i) disable iff (!nrst_i)
      state_ff == BST_UIR |=> ir_ff == $past(ir_sh_ff))
      else $error("instruction not updated");
   chk_byp_shift: assert property (
      @(posedge tck_i) disable iff (!nrst_i)
      state_ff == BST_SHDR && dec.sel_byp |=> byp_ff == $past(tdi_i))
      else $error("bypass did not take serial input");
   chk_bsr_lsb: assert property (
      @(posedge tck_i) disable iff (!nrst_i)
      state_ff == BST_SHDR && dec.sel_bsr
      |=> bsr_ff[BST_BSR_W-2:0] == $past(bsr_ff[BST_BSR_W-1:1]))
      else $error("boundary chain not shifted toward output");
   chk_capture_pins: assert property (
      @(posedge tck_i) disable iff (!nrst_i)
      state_ff == BST_CDR && dec.sel_bsr
      |=> bsr_ff[BST_BSR_W-2:0] == $past(pin_q_ff & ~NC_MASK[BST_BSR_W-2:0])
      && bsr_ff[BST_OE_IDX] == $past(upd_ff[BST_OE_IDX]))
      else $error("pin states not captured");
   chk_bus_gate: assert property (
      @(posedge mclk_i) disable iff (!nrst_i)
      ext_sy_ff[2] && ext_sy_ff[1] && oe_sy_ff[2] == oe_sy_ff[1]
      |=> outbus_en_o == $past(oe_sy_ff[2]))
      else $error("output bus does not follow cell 89 under test drive");
   chk_bus_off: assert property (
      @(posedge mclk_i) disable iff (!nrst_i)
      !ext_sy_ff[2] && !ext_sy_ff[1] |=> !outbus_en_o && !test_drive_o)
      else $error("output bus driven outside test drive");
   chk_hiz_follow: assert property (
      @(posedge mclk_i) disable iff (!nrst_i)
      hiz_sy_ff[2] && hiz_sy_ff[1] |=> out_hiz_o)
      else $error("high impedance not forced");
   cov_extest: cover property (@(posedge tck_i) disable iff (!nrst_i)
      state_ff == BST_UDR && dec.extest);
   cov_idcode: cover property (@(posedge tck_i) disable iff (!nrst_i)
      state_ff == BST_SHDR && dec.sel_id);
   cov_bypass: cover property (@(posedge tck_i) disable iff (!nrst_i)
      state_ff == BST_SHDR && dec.sel_byp);
   cov_sampz: cover property (@(posedge tck_i) disable iff (!nrst_i)
      state_ff == BST_UDR && dec.force_hiz);
endmodule
`default_nettype wire

// >>> test/bst_ctl_model.sv
`timescale 1ns/1ps
`default_nettype none
module bst_ctl_model (
   output logic tck_o,
   output logic tms_o,
   output logic tdi_o,
   input wire logic tdo_i
);
   // ****
   // Board test controller
   // ****
   initial begin
      tck_o = 1'h0;
      tms_o = 1'h1;
      tdi_o = 1'h0;
   end
   // One test clock; tck rests low between frames, tdi toggles after hold
   task automatic step(input logic tms, input logic tdi, output logic tdo);
      #1 tms_o = tms;
      tdi_o = tdi;
      #14 tck_o = 1'h1;
      tdo = tdo_i;
      #5 tdi_o = ~tdi_o;
      #10 tck_o = 1'h0;
   endtask
   // Five ones reach reset, then park in idle
   task automatic tlr();
      logic d;
      repeat (5) step(1'h1, 1'h0, d);
      step(1'h0, 1'h0, d);
   endtask
   // Full scan from idle back to idle, low bit first
   task automatic scan(input logic ir, input logic [88:0] din, input int n,
                       output logic [88:0] dout);
      logic d;
      dout = '0;
      step(1'h1, 1'h0, d);
      if (ir) begin
         step(1'h1, 1'h0, d);
      end
      step(1'h0, 1'h0, d);
      step(1'h0, 1'h0, d);
      for (int i = 0; i < n; i++) begin
         step(i == n - 1, din[i], d);
         dout[i] = d;
      end
      step(1'h1, 1'h0, d);
      step(1'h0, 1'h0, d);
   endtask
endmodule
`default_nettype wire

// >>> test/sram_boundary_scan_tap_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module sram_boundary_scan_tap_tb_top
   import bst_pkg::*;
;
   localparam logic [31:0] ID = 32'h1234_5670; // Arbitrary value
   localparam logic [88:0] NC = 89'h8; // Cell 4 has no ball
   logic mclk, nrst, tck, tms, tdi, tdo, tdo_oe, drv, hiz, oben, d;
   logic [87:0] pins_in, pins_out;
   logic [88:0] v;
   int mismatches = 0;
   int n_tests = 0;
   int cycles = 0;
   wire logic tdo_w = tdo_oe ? tdo : 1'hZ;
   // ****
   // Design and controller
   // ****
   bst_tap #(.ID_VALUE(ID), .NC_MASK(NC)) bst_tap_inst (.mclk_i(mclk),
      .nrst_i(nrst), .tck_i(tck), .tms_i(tms), .tdi_i(tdi), .tdo_o(tdo),
      .tdo_oe_o(tdo_oe), .pins_i(pins_in), .pins_o(pins_out),
      .test_drive_o(drv), .out_hiz_o(hiz), .outbus_en_o(oben));
   bst_ctl_model bst_ctl_model_inst (.tck_o(tck), .tms_o(tms), .tdi_o(tdi),
      .tdo_i(tdo_w));
   // System clock and hang limit
   initial begin
      mclk = 1'h0;
      forever #2 mclk = ~mclk;
   end
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 20000) begin
         mismatches++;
         give_verdict();
      end
   end
   // ****
   // Helpers
   // ****
   task automatic give_verdict();
      $display("mismatches=%0d n_tests=%0d", mismatches, n_tests);
      if (mismatches == 0 && n_tests > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task automatic cmp(input logic [88:0] got, input logic [88:0] exp);
      n_tests++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // Load a code and check the fixed capture pattern
   task automatic load(input logic [2:0] code);
      bst_ctl_model_inst.scan(1'h1, {86'h0, code}, 3, v);
      cmp(v, {86'h0, BST_IR_CAPT});
      settle();
   endtask
   task automatic settle();
      repeat (8) @(posedge mclk);
      #1;
   endtask
   task automatic set_pins(input logic [87:0] p);
      @(posedge mclk);
      #1 pins_in = p;
   endtask
   // ****
   // Scenarios
   // ****
   task automatic t_idcode();
      cmp({tdo_oe, drv, hiz}, 89'h0);
      bst_ctl_model_inst.scan(1'h0, 89'hA5, 40, v);
      cmp(v, {49'h0, 8'hA5, ID | 32'h1});
   endtask
   task automatic t_bypass();
      load(BST_I_BYPASS);
      bst_ctl_model_inst.scan(1'h0, 89'h5, 4, v);
      cmp(v, 89'hA);
      cmp({drv, hiz}, 89'h0);
   endtask
   task automatic t_sample();
      set_pins(88'hC3_5A5A_0F0F_1234_FFFF_000F);
      load(BST_I_SAMPLE);
      bst_ctl_model_inst.scan(1'h0,
         {1'h0, 88'h0F_1E2D_3C4B_5A69_7887_9600}, 89, v);
      cmp(v, {1'h1, pins_in & ~NC[87:0]});
      cmp(pins_out, 88'h0F_1E2D_3C4B_5A69_7887_9600);
      cmp({drv, hiz}, 89'h0);
   endtask
   task automatic t_extest();
      set_pins(88'h55_AAAA_5555_AAAA_5555_AAA9);
      load(BST_I_EXTEST);
      cmp({drv, hiz, oben}, 89'h6);
      bst_ctl_model_inst.scan(1'h0, {1'h1, 88'h0}, 89, v);
      cmp(v, {1'h0, pins_in & ~NC[87:0]});
      settle();
      cmp({drv, hiz, oben}, 89'h7);
      bst_ctl_model_inst.scan(1'h0, 89'h0, 89, v);
      settle();
      cmp(oben, 1'h0);
   endtask
   task automatic t_sampz();
      load(BST_I_SAMPZ);
      cmp({drv, hiz}, 89'h1);
      bst_ctl_model_inst.scan(1'h0, {1'h0, {88{1'b1}}}, 89, v);
      cmp(v, {1'h0, pins_in & ~NC[87:0]});
      cmp(pins_out, {88{1'b1}});
   endtask
   task automatic t_reset_state();
      bst_ctl_model_inst.tlr();
      settle();
      cmp({hiz, pins_out}, 89'h0);
      cmp(drv, 1'h0);
      load(BST_I_SAMPLE);
      bst_ctl_model_inst.scan(1'h0, 89'h0, 89, v);
      cmp(v[88], 1'h1);
   endtask
   // Reset with one test clock inside, then run all scenarios
   initial begin
      nrst = 1'h0;
      pins_in = '0;
      fork
         bst_ctl_model_inst.step(1'h1, 1'h0, d);
         repeat (10) @(posedge mclk);
      join
      #1 nrst = 1'h1;
      bst_ctl_model_inst.tlr();
      settle();
      t_idcode();
      t_bypass();
      t_sample();
      t_extest();
      t_sampz();
      t_reset_state();
      give_verdict();
   end
endmodule
`default_nettype wire
